// *** core/tcmon_pkg.sv ***
// Package for the trip circuit monitor: register map, field layout, reset values, timing
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus
package tcmon_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DELAY_UNIT_US = 1000;
  localparam int unsigned DELAY_UNIT_CYC = DELAY_UNIT_US * CLK_MHZ;
  localparam int unsigned NUM_INPUTS = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_DELAY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam int unsigned CTRL_PLAN_BIT = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  localparam int unsigned CTRL_FUNC_BIT = 2;
  localparam int unsigned CTRL_BLKEN_BIT = 3;
  localparam int unsigned CTRL_POSSRC_BIT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  localparam logic [15:0] DELAY_RST = 16'h0001;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    TCMON_IDLE = 3'b001,
    TCMON_TIMING = 3'b010,
    TCMON_ALARM = 3'b100
  } tcmon_state_t;
endpackage

// *** core/tcmon_top.sv ***
// Trip circuit monitor: watches the breaker trip circuit through selected digital inputs
// Assumes inputs synchronous to aclk; configuration over AXI4-Lite
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tcmon_top
  import tcmon_pkg::*;
#(
  parameter int unsigned UNIT_CYC = tcmon_pkg::DELAY_UNIT_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  slot_inputs,
  input  wire logic        switchgear_position_signal,
  input  wire logic        breaker_closed_aux_contact,
  input  wire logic        external_block_first,
  input  wire logic        external_block_second,
  output logic             alarm,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import tcmon_pkg::*;

  // Selector code 0 means unassigned, 1..8 pick slot one inputs
  function automatic logic pick_input(input logic [3:0] sel, input logic [7:0] ins);
    logic r;
    r = 1'b1;
    if (sel != 4'h0 && sel <= 4'h8) begin
      r = ins[3'(sel - 4'h1)];
    end
    return r;
  endfunction

  function automatic logic sel_valid(input logic [3:0] sel);
    return (sel != 4'h0) && (sel <= 4'h8);
  endfunction

  logic [31:0]  ctrl_q;
  logic [7:0]   sel_q;
  logic [15:0]  delay_q;
  logic [1:0]   irq_stat_q;
  logic [1:0]   irq_mask_q;
  tcmon_state_t state_q;
  logic [31:0]  unit_cnt_q;
  logic [15:0]  dly_cnt_q;
  logic [7:0]   aw_addr_q;
  logic         aw_have_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;
  logic         w_have_q;

  // Configuration decode
  logic enabled, mode_either, blk_allowed, breaker_closed, monitoring, blocked, fault;
  logic in1, in2;
  assign enabled = ctrl_q[CTRL_PLAN_BIT] & ctrl_q[CTRL_FUNC_BIT];
  assign mode_either = ctrl_q[CTRL_MODE_BIT];
  assign blk_allowed = ctrl_q[CTRL_BLKEN_BIT];
  // Position source: switchgear signal or the closed aux contact directly
  assign breaker_closed = ctrl_q[CTRL_POSSRC_BIT] ? breaker_closed_aux_contact
                                                  : switchgear_position_signal;
  assign blocked = blk_allowed & (external_block_first | external_block_second);
  assign in1 = pick_input(sel_q[3:0], slot_inputs);
  assign in2 = pick_input(sel_q[7:4], slot_inputs);
  // Closed-only supervises while closed; either mode always
  assign monitoring = enabled & ~blocked & (mode_either | breaker_closed);
  // Dead supply drops the inputs, which reads as a broken circuit
  always_comb begin
    fault = 1'b0;
    if (monitoring) begin
      if (breaker_closed) begin
        fault = sel_valid(sel_q[3:0]) & ~in1;
      end else begin
        fault = mode_either & sel_valid(sel_q[7:4]) & ~in2;
      end
    end
  end

  // Delay prescaler ticks once per delay unit while timing
  logic unit_tick;
  assign unit_tick = (unit_cnt_q == UNIT_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != TCMON_TIMING || !fault) begin
      unit_cnt_q <= 32'h0000_0000;
    end else if (unit_tick) begin
      unit_cnt_q <= 32'h0000_0000;
    end else begin
      unit_cnt_q <= unit_cnt_q + 32'h0000_0001;
    end
  end

  // Alarm state machine; any gap in the fault restarts the wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= TCMON_IDLE;
      dly_cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        TCMON_IDLE: begin
          dly_cnt_q <= 16'h0000;
          if (fault) begin
            state_q <= TCMON_TIMING;
          end
        end
        TCMON_TIMING: begin
          if (!fault) begin
            state_q <= TCMON_IDLE;
            dly_cnt_q <= 16'h0000;
          end else if (unit_tick) begin
            if (dly_cnt_q + 16'h0001 >= delay_q) begin
              state_q <= TCMON_ALARM;
            end
            dly_cnt_q <= dly_cnt_q + 16'h0001;
          end
        end
        TCMON_ALARM: begin
          if (!fault) begin
            state_q <= TCMON_IDLE;
          end
        end
      endcase
    end
  end

  // Alarm output registered from the alarm state gated by the live fault
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm <= 1'b0;
    end else begin
      alarm <= (state_q == TCMON_ALARM) & fault;
    end
  end

  // Events: bit 0 alarm raised, bit 1 alarm cleared
  logic alarm_rise, alarm_fall, stat_rd;
  logic [1:0] ev;
  assign alarm_rise = (state_q == TCMON_ALARM) & fault & ~alarm;
  assign alarm_fall = alarm & ~((state_q == TCMON_ALARM) & fault);
  assign ev = {alarm_fall, alarm_rise};
  assign stat_rd = s_axi_arvalid & s_axi_arready & (s_axi_araddr[7:2] == OFS_IRQ_STAT[7:2]);

  // Sticky status; a new event wins over the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (stat_rd ? 2'h0 : irq_stat_q) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((stat_rd ? 2'h0 : irq_stat_q) | ev) & irq_mask_q);
    end
  end

  // Write channel: address and data taken in either order
  logic do_write;
  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_q[7:2])
          OFS_CTRL[7:2], OFS_SEL[7:2], OFS_DELAY[7:2], OFS_STATUS[7:2],
          OFS_IRQ_STAT[7:2], OFS_IRQ_MASK[7:2]: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers with byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      sel_q <= SEL_RST[7:0];
      delay_q <= DELAY_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (do_write) begin
      if (aw_addr_q[7:2] == OFS_CTRL[7:2] && w_strb_q[0]) begin
        ctrl_q <= {27'h0, w_data_q[4:0]};
      end
      if (aw_addr_q[7:2] == OFS_SEL[7:2] && w_strb_q[0]) begin
        sel_q <= w_data_q[7:0];
      end
      if (aw_addr_q[7:2] == OFS_DELAY[7:2]) begin
        if (w_strb_q[0]) delay_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1]) delay_q[15:8] <= w_data_q[15:8];
      end
      if (aw_addr_q[7:2] == OFS_IRQ_MASK[7:2] && w_strb_q[0]) begin
        irq_mask_q <= w_data_q[1:0];
      end
    end
  end

  // Read channel: one cycle to arready, data the cycle after
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr[7:2])
          OFS_CTRL[7:2]: s_axi_rdata <= ctrl_q;
          OFS_SEL[7:2]: s_axi_rdata <= {24'h0, sel_q};
          OFS_DELAY[7:2]: s_axi_rdata <= {16'h0, delay_q};
          OFS_STATUS[7:2]: s_axi_rdata <= {28'h0, state_q[2], fault, monitoring, alarm};
          OFS_IRQ_STAT[7:2]: s_axi_rdata <= {30'h0, irq_stat_q};
          OFS_IRQ_MASK[7:2]: s_axi_rdata <= {30'h0, irq_mask_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks; each property sits right above its assertion
  property p_no_alarm_unmon;
    @(posedge aclk) disable iff (!aresetn)
    !monitoring |=> !alarm;
  endproperty
  a_no_alarm_unmon: assert property (p_no_alarm_unmon)
    else $error("alarm while not monitoring");
  property p_closed_only;
    @(posedge aclk) disable iff (!aresetn)
    (!mode_either && !breaker_closed) |-> !fault;
  endproperty
  a_closed_only: assert property (p_closed_only)
    else $error("fault outside closed position in closed mode");
  property p_block;
    @(posedge aclk) disable iff (!aresetn)
    blocked |-> !fault;
  endproperty
  a_block: assert property (p_block)
    else $error("fault while blocked");
  property p_disabled;
    @(posedge aclk) disable iff (!aresetn)
    !enabled |-> !fault;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("fault while disabled");
  property p_no_early;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == TCMON_IDLE) |=> !alarm;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("alarm without delay");
  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    !fault |=> !alarm;
  endproperty
  a_clear: assert property (p_clear)
    else $error("alarm not cleared");
  property p_restart;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == TCMON_TIMING && !fault) |=> (state_q == TCMON_IDLE && dly_cnt_q == 16'h0000);
  endproperty
  a_restart: assert property (p_restart)
    else $error("delay not restarted");
  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
    alarm_rise |=> irq_stat_q[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event lost");
  property p_rise_from_alarm;
    @(posedge aclk) disable iff (!aresetn)
    $rose(alarm) |-> ($past(state_q) == TCMON_ALARM);
  endproperty
  a_rise_from_alarm: assert property (p_rise_from_alarm)
    else $error("alarm raised without the delay state");
  property p_closed_uses_first;
    @(posedge aclk) disable iff (!aresetn)
    (monitoring && breaker_closed && sel_valid(sel_q[3:0]) && !in1) |-> fault;
  endproperty
  a_closed_uses_first: assert property (p_closed_uses_first)
    else $error("dropped closed-state input not seen as fault");
  property p_open_uses_second;
    @(posedge aclk) disable iff (!aresetn)
    (monitoring && mode_either && !breaker_closed && sel_valid(sel_q[7:4]) && !in2) |-> fault;
  endproperty
  a_open_uses_second: assert property (p_open_uses_second)
    else $error("dropped open-state input not seen as fault");
  property p_wr_pending;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready);
  endproperty
  a_wr_pending: assert property (p_wr_pending)
    else $error("write accepted while a response is pending");
endmodule // tcmon_top
`default_nettype wire

// *** test/tcmon_breaker_model.sv ***
// Breaker trip circuit model: coil, both auxiliary contacts and trip supply
// Assumes the bench steers breaker state and faults as levels synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module tcmon_breaker_model (
  input  wire logic       closed,
  input  wire logic       coil_ok,
  input  wire logic       supply_ok,
  input  wire logic       sg_ok,
  output logic [7:0]      slot_inputs,
  output logic            switchgear_position_signal,
  output logic            breaker_closed_aux_contact
);
  // Closed contact loops input one, open contact input two, each on its own return;
  // spares hang on the trip supply too, so losing it drops every input
  assign slot_inputs = {{6{supply_ok}},
                        supply_ok & coil_ok & ~closed,
                        supply_ok & coil_ok & closed};
  // Switchgear view can disagree with the real contact, to expose the source choice
  assign switchgear_position_signal = closed & sg_ok;
  assign breaker_closed_aux_contact = closed;
endmodule // tcmon_breaker_model
`default_nettype wire

// *** test/tb_top.sv ***
// Bench for the trip circuit monitor: AXI4-Lite register tasks and alarm scenarios
// Assumes the breaker model on the slot inputs and UNIT_CYC shortened to 4 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tcmon_pkg::*;
  localparam int unsigned UNIT = 4;
  logic        aclk, aresetn, alarm, irq, cl, co, su, sg, b1, b2, sgpos, aux;
  logic [7:0]  slot, awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          n_mismatch, num_checks, cyc;

  // Free running 100 MHz clock
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  tcmon_breaker_model tcmon_breaker_model_inst (.closed(cl), .coil_ok(co), .supply_ok(su), .sg_ok(sg),
    .slot_inputs(slot), .switchgear_position_signal(sgpos), .breaker_closed_aux_contact(aux));

  tcmon_top #(.UNIT_CYC(UNIT)) tcmon_top_inst (.aclk(aclk), .aresetn(aresetn), .slot_inputs(slot),
    .switchgear_position_signal(sgpos), .breaker_closed_aux_contact(aux), .external_block_first(b1),
    .external_block_second(b2), .alarm(alarm), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Cut a hang short well past the few hundred cycles the tests need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task run(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task endt(input string s);
    $display("test %s done, %0d mismatches so far", s, n_mismatch);
  endtask

  // One AXI4-Lite transfer; each channel is held until its own handshake edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    logic done;
    t = 0;
    done = 1'b0;
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done && t < 50) begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        rs = bresp;
        done = 1'b1;
      end
      if (rvalid && rready) begin
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
        done = 1'b1;
      end
    end
    if (!done) n_mismatch++;
    // Spare edge so the next transfer never reassigns a strobe in the same step
    @(posedge aclk);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Apply a breaker picture {closed, coil, supply, switchgear, block1, block2}, judge alarm, heal
  task trial(input logic [31:0] c, input logic [5:0] v, input logic e);
    bus(1'b1, OFS_CTRL, c);
    {cl, co, su, sg, b1, b2} <= v;
    run(20);
    chk({31'h0, alarm}, {31'h0, e});
    {cl, co, su, sg, b1, b2} <= 6'b111100;
    run(4);
    chk({31'h0, alarm}, 32'h0);
  endtask

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    {cl, co, su, sg, b1, b2} = 6'b111100;
    run(3);
    aresetn <= 1'b1;
    run(1);
    rdchk(OFS_CTRL, CTRL_RST);
    rdchk(OFS_SEL, SEL_RST);
    rdchk(OFS_DELAY, {16'h0, DELAY_RST});
    rdchk(OFS_IRQ_MASK, 32'h0);
    rdchk(8'h18, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    bus(1'b1, 8'h1c, 32'h5);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    endt("reset");
    bus(1'b1, OFS_SEL, 32'h21);
    bus(1'b1, OFS_DELAY, 32'h3);
    bus(1'b1, OFS_IRQ_MASK, 32'h3);
    bus(1'b1, OFS_CTRL, 32'h5);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    co <= 1'b0;
    run(9);
    chk({31'h0, alarm}, 32'h0);
    run(7);
    chk({31'h0, alarm}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    // Status: alarm state, fault, monitoring, alarm all set
    rdchk(OFS_STATUS, 32'hf);
    rdchk(OFS_IRQ_STAT, 32'h1);
    rdchk(OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    co <= 1'b1;
    run(4);
    chk({31'h0, alarm}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rdchk(OFS_IRQ_STAT, 32'h2);
    // Healthy and closed: only the monitoring bit stays up
    rdchk(OFS_STATUS, 32'h2);
    endt("delay and interrupt");
    // Look while the fault still stands, so a delay that keeps counting is caught
    repeat (3) begin
      co <= 1'b0;
      run(9);
      chk({31'h0, alarm}, 32'h0);
      co <= 1'b1;
      run(2);
    end
    rdchk(OFS_IRQ_STAT, 32'h0);
    endt("restart");
    trial(32'h05, 6'b001100, 1'b0);
    trial(32'h05, 6'b101100, 1'b1);
    trial(32'h07, 6'b001100, 1'b1);
    trial(32'h07, 6'b110100, 1'b1);
    trial(32'h04, 6'b101100, 1'b0);
    trial(32'h01, 6'b101100, 1'b0);
    trial(32'h0d, 6'b101110, 1'b0);
    trial(32'h0d, 6'b101101, 1'b0);
    trial(32'h05, 6'b101110, 1'b1);
    trial(32'h05, 6'b101000, 1'b0);
    trial(32'h15, 6'b101000, 1'b1);
    bus(1'b1, OFS_SEL, 32'h0);
    trial(32'h05, 6'b101100, 1'b0);
    endt("modes");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
